// ### rtl/isx_pkg.sv
/*
 * isx_pkg: shared types and constants for the instruction subset executor.
 * assumes the core decodes opcodes into isx_op_t before handing them over.
 */
package isx_pkg;

   // data path and operand field widths
   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   localparam int BRK_W = 11;
   localparam int PC_W = 15;
   localparam int LATCH_W = 7;

   // high latch field that feeds the upper program counter bits
   localparam int LATCH_HI_POS = 6;
   localparam int LATCH_LO_POS = 3;

   // destination select encodings
   localparam logic DEST_ACC = 1'h0;
   localparam logic DEST_FILE = 1'h1;

   // reset values and byte constants
   localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
   localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
   localparam logic [PC_W-1:0] PC_RST = 15'h0000;
   localparam logic [FADDR_W-1:0] FADDR_RST = 7'h00;

   // cycle counts
   localparam int CYC_SHORT = 1;
   localparam int CYC_LONG = 2;

   // decoded operations of this group
   typedef enum logic [3:0] {
      ISX_OP_NONE,
      ISX_OP_DEC_SKIP,
      ISX_OP_BRANCH,
      ISX_OP_INC,
      ISX_OP_INC_SKIP,
      ISX_OP_OR_LIT,
      ISX_OP_OR_FILE,
      ISX_OP_SHL,
      ISX_OP_SHR
   } isx_op_t;

   // one decoded instruction word
   typedef struct packed {
      isx_op_t op;                 // operation
      logic [FADDR_W-1:0] faddr;   // file register address
      logic dest;                  // destination select
      logic [BRK_W-1:0] lit;       // branch target or literal in low byte
   } isx_instr_t;

   // file register write request
   typedef struct packed {
      logic we;
      logic [FADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } isx_fwr_t;

endpackage : isx_pkg

// ### rtl/isx_exec.sv
/*
 * isx_exec: executes the decrement/increment, skip, branch, inclusive or
 * and logical shift group of an 8-bit core, at most one instruction per cycle.
 * assumes the fetch logic presents a decoded word with the addressed file
 * register's value in the same cycle, and honours NOP_CYCLE by not
 * executing whatever it fetched during that cycle.
 */
// Functional notes
// - dest bit 0 to accumulator, 1 to file
// - decrement-skip subtracts one, result to destination
// - zero decrement result: next becomes nop, two cycles
// - nonzero skip result: next executes normally
// - increments add one, result to destination
// - zero increment-skip result: next becomes nop
// - branch loads 11-bit immediate into pc[10:0]
// - branch pc[14:11] from high latch bits [6:3]
// - branch always takes two cycles
// - or literal into accumulator, always to accumulator
// - or accumulator with file, result to destination
// - shift left: bit7 to carry, bits 6:0 up
// - shift left inserts zero lsb, updates carry, zero
// - shift right: bit0 to carry, zero msb
module isx_exec (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RESETN,
   // decoded instruction from fetch
   input wire logic INSTR_VALID,
   input wire isx_pkg::isx_instr_t INSTR,
   input wire logic [isx_pkg::DATA_W-1:0] FILE_RDATA,
   input wire logic [isx_pkg::LATCH_W-1:0] PC_HIGH_LATCH,
   // file register write
   output isx_pkg::isx_fwr_t FILE_WR,
   // core state
   output logic [isx_pkg::DATA_W-1:0] ACC,
   output logic CARRY,
   output logic ZERO,
   // program flow
   output logic PC_LOAD,
   output logic [isx_pkg::PC_W-1:0] PC_TARGET,
   output logic NOP_CYCLE,
   output logic SKIP_TAKEN
);

   // flow state
   logic busy_r;                  // second cycle of a two-cycle op
   logic acc_en;                  // instruction accepted this cycle
   // combinational result of the accepted op
   logic [isx_pkg::DATA_W-1:0] res;
   logic res_zero;
   logic to_file;                 // result goes to the file register
   logic to_acc;                  // result goes to the accumulator
   logic upd_z;                   // op updates zero flag
   logic upd_c;                   // op updates carry flag
   logic new_c;                   // carry value for shifts
   logic is_skip;                 // skip-on-zero op
   logic long_op;                 // op needs a second, nop cycle
   // registered state behind the outputs
   logic [isx_pkg::DATA_W-1:0] acc_r;
   logic c_r;
   logic z_r;
   isx_pkg::isx_fwr_t fwr_r;
   logic pc_load_r;
   logic [isx_pkg::PC_W-1:0] pc_tgt_r;
   logic skip_r;

   // a word arriving during the nop cycle is the discarded one
   assign acc_en = INSTR_VALID && !busy_r;

   // result, destination and flag selection
   always_comb begin
      res = isx_pkg::ZERO_BYTE;
      upd_z = 1'b0;
      upd_c = 1'b0;
      new_c = 1'b0;
      is_skip = 1'b0;
      to_file = 1'b0;
      to_acc = 1'b0;
      case (INSTR.op)
         isx_pkg::ISX_OP_DEC_SKIP: begin
            res = FILE_RDATA - isx_pkg::ONE_BYTE;
            is_skip = 1'b1;
         end
         isx_pkg::ISX_OP_INC: begin
            res = FILE_RDATA + isx_pkg::ONE_BYTE;
            upd_z = 1'b1;
         end
         isx_pkg::ISX_OP_INC_SKIP: begin
            res = FILE_RDATA + isx_pkg::ONE_BYTE;
            is_skip = 1'b1;
         end
         isx_pkg::ISX_OP_OR_LIT: begin
            res = acc_r | INSTR.lit[isx_pkg::DATA_W-1:0];
            upd_z = 1'b1;
         end
         isx_pkg::ISX_OP_OR_FILE: begin
            res = acc_r | FILE_RDATA;
            upd_z = 1'b1;
         end
         isx_pkg::ISX_OP_SHL: begin
            res = {FILE_RDATA[isx_pkg::DATA_W-2:0], 1'b0};
            new_c = FILE_RDATA[isx_pkg::DATA_W-1];
            upd_z = 1'b1;
            upd_c = 1'b1;
         end
         isx_pkg::ISX_OP_SHR: begin
            res = {1'b0, FILE_RDATA[isx_pkg::DATA_W-1:1]};
            new_c = FILE_RDATA[0];
            upd_z = 1'b1;
            upd_c = 1'b1;
         end
         default: begin
            // branch and idle produce no data result
            res = isx_pkg::ZERO_BYTE;
         end
      endcase
      // literal or and the branch ignore the destination bit
      case (INSTR.op)
         isx_pkg::ISX_OP_NONE,
         isx_pkg::ISX_OP_BRANCH: begin
            to_acc = 1'b0;
         end
         isx_pkg::ISX_OP_OR_LIT: begin
            to_acc = 1'b1;
         end
         default: begin
            to_file = (INSTR.dest == isx_pkg::DEST_FILE);
            to_acc = (INSTR.dest == isx_pkg::DEST_ACC);
         end
      endcase
   end

   assign res_zero = (res == isx_pkg::ZERO_BYTE);
   // branch always long; skip long only on a zero result
   assign long_op = (INSTR.op == isx_pkg::ISX_OP_BRANCH)
      || (is_skip && res_zero);

   // nop cycle tracking
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         busy_r <= 1'b0;
         skip_r <= 1'b0;
      end else begin
         busy_r <= acc_en && long_op;
         skip_r <= acc_en && is_skip && res_zero;
      end
   end

   // accumulator
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         acc_r <= isx_pkg::ACC_RST;
      end else if (acc_en && to_acc) begin
         acc_r <= res;
      end
   end

   // status flags; skip and branch ops leave both alone
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         c_r <= 1'b0;
         z_r <= 1'b0;
      end else if (acc_en) begin
         if (upd_z) begin
            z_r <= res_zero;
         end
         if (upd_c) begin
            c_r <= new_c;
         end
      end
   end

   // file write port, a one-cycle strobe
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         fwr_r <= '{we: 1'b0, addr: isx_pkg::FADDR_RST, data: isx_pkg::ZERO_BYTE};
      end else begin
         fwr_r.we <= acc_en && to_file;
         if (acc_en && to_file) begin
            fwr_r.addr <= INSTR.faddr;
            fwr_r.data <= res;
         end
      end
   end

   // branch target; the latch field wins over the narrower description
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         pc_load_r <= 1'b0;
         pc_tgt_r <= isx_pkg::PC_RST;
      end else begin
         pc_load_r <= acc_en && (INSTR.op == isx_pkg::ISX_OP_BRANCH);
         if (acc_en && (INSTR.op == isx_pkg::ISX_OP_BRANCH)) begin
            pc_tgt_r <= {PC_HIGH_LATCH[isx_pkg::LATCH_HI_POS:isx_pkg::LATCH_LO_POS],
                         INSTR.lit};
         end
      end
   end

   // outputs straight from flip-flops
   assign ACC = acc_r;
   assign CARRY = c_r;
   assign ZERO = z_r;
   assign FILE_WR = fwr_r;
   assign PC_LOAD = pc_load_r;
   assign PC_TARGET = pc_tgt_r;
   assign NOP_CYCLE = busy_r;
   assign SKIP_TAKEN = skip_r;

   // assertions
   sequence s_skip_zero;
      acc_en && is_skip && res_zero;
   endsequence

   sequence s_nop_then_free;
      NOP_CYCLE && SKIP_TAKEN ##1 !NOP_CYCLE;
   endsequence

   property p_dest_file;
      @(posedge REF_CLK) disable iff (!RESETN)
      acc_en && is_skip && INSTR.dest
      |=> FILE_WR.we && FILE_WR.addr == $past(INSTR.faddr)
      && FILE_WR.data == (($past(INSTR.op) == isx_pkg::ISX_OP_DEC_SKIP)
      ? $past(FILE_RDATA) - isx_pkg::ONE_BYTE : $past(FILE_RDATA) + isx_pkg::ONE_BYTE);
   endproperty
   a_dest_file: assert property (p_dest_file) else $error("file dest not written");

   property p_dec;
      @(posedge REF_CLK) disable iff (!RESETN)
      acc_en && INSTR.op == isx_pkg::ISX_OP_DEC_SKIP && !INSTR.dest
      |=> ACC == $past(FILE_RDATA) - isx_pkg::ONE_BYTE;
   endproperty
   a_dec: assert property (p_dec) else $error("decrement result wrong");

   property p_skip_zero;
      @(posedge REF_CLK) disable iff (!RESETN)
      s_skip_zero |=> s_nop_then_free;
   endproperty
   a_skip_zero: assert property (p_skip_zero) else $error("zero skip lacks nop");

   property p_skip_nonzero;
      @(posedge REF_CLK) disable iff (!RESETN)
      acc_en && is_skip && !res_zero |=> !NOP_CYCLE && !SKIP_TAKEN;
   endproperty
   a_skip_nonzero: assert property (p_skip_nonzero) else $error("nonzero skip stalled");

   property p_inc;
      @(posedge REF_CLK) disable iff (!RESETN)
      acc_en && INSTR.op == isx_pkg::ISX_OP_INC && !INSTR.dest
      |=> ACC == $past(FILE_RDATA) + isx_pkg::ONE_BYTE && ZERO == (ACC == isx_pkg::ZERO_BYTE);
   endproperty
   a_inc: assert property (p_inc) else $error("increment wrong");

   property p_branch;
      @(posedge REF_CLK) disable iff (!RESETN)
      acc_en && INSTR.op == isx_pkg::ISX_OP_BRANCH
      |=> PC_LOAD && NOP_CYCLE && PC_TARGET == {$past(PC_HIGH_LATCH[6:3]), $past(INSTR.lit)}
      ##1 !PC_LOAD && !NOP_CYCLE;
   endproperty
   a_branch: assert property (p_branch) else $error("branch target or length wrong");

   property p_or_lit;
      @(posedge REF_CLK) disable iff (!RESETN)
      acc_en && INSTR.op == isx_pkg::ISX_OP_OR_LIT
      |=> ACC == ($past(ACC) | $past(INSTR.lit[7:0])) && !FILE_WR.we;
   endproperty
   a_or_lit: assert property (p_or_lit) else $error("or literal wrong");

   property p_shl;
      @(posedge REF_CLK) disable iff (!RESETN)
      acc_en && INSTR.op == isx_pkg::ISX_OP_SHL && INSTR.dest
      |=> CARRY == $past(FILE_RDATA[7]) && FILE_WR.data == {$past(FILE_RDATA[6:0]), 1'b0};
   endproperty
   a_shl: assert property (p_shl) else $error("left shift wrong");

   property p_shr;
      @(posedge REF_CLK) disable iff (!RESETN)
      acc_en && INSTR.op == isx_pkg::ISX_OP_SHR && !INSTR.dest
      |=> CARRY == $past(FILE_RDATA[0]) && ACC == {1'b0, $past(FILE_RDATA[7:1])};
   endproperty
   a_shr: assert property (p_shr) else $error("right shift wrong");

   property p_flags_kept;
      @(posedge REF_CLK) disable iff (!RESETN)
      acc_en && (is_skip || INSTR.op == isx_pkg::ISX_OP_BRANCH) |=> $stable(ZERO) && $stable(CARRY);
   endproperty
   a_flags_kept: assert property (p_flags_kept) else $error("skip or branch moved a flag");

   property p_or_file;
      @(posedge REF_CLK) disable iff (!RESETN)
      acc_en && INSTR.op == isx_pkg::ISX_OP_OR_FILE && INSTR.dest
      |=> FILE_WR.we && FILE_WR.data == ($past(ACC) | $past(FILE_RDATA)) && $stable(ACC);
   endproperty
   a_or_file: assert property (p_or_file) else $error("or file wrong");

   // a word offered in the nop cycle must leave no trace anywhere
   property p_refused;
      @(posedge REF_CLK) disable iff (!RESETN)
      NOP_CYCLE && INSTR_VALID
      |=> !FILE_WR.we && !PC_LOAD && $stable(ACC) && $stable(ZERO) && $stable(CARRY);
   endproperty
   a_refused: assert property (p_refused) else $error("word in nop cycle took effect");

   // left shift into the accumulator: zero lsb, zero flag follows result
   property p_shl_acc;
      @(posedge REF_CLK) disable iff (!RESETN)
      acc_en && INSTR.op == isx_pkg::ISX_OP_SHL && !INSTR.dest
      |=> ACC[0] == 1'b0 && ZERO == (ACC == isx_pkg::ZERO_BYTE) && !FILE_WR.we;
   endproperty
   a_shl_acc: assert property (p_shl_acc) else $error("left shift to accumulator wrong");

endmodule // isx_exec

// ### sim/isx_file_model.sv
/*
 * isx_file_model: file register space seen by the executor.
 * assumes the bench preloads operands through mem before each word.
 */
module isx_file_model (
   // clock
   input wire logic clk,
   // read port, same cycle as the word
   input wire logic [isx_pkg::FADDR_W-1:0] addr,
   output logic [isx_pkg::DATA_W-1:0] rdata,
   // write port from the executor
   input wire isx_pkg::isx_fwr_t wr
);
   timeunit 1ns;
   timeprecision 1ps;

   // 128 registers; plain always so the bench may preload too
   logic [isx_pkg::DATA_W-1:0] mem [128];

   // combinational read of the addressed register
   assign rdata = mem[addr];

   // write-back when the executor targets the file
   always @(posedge clk) begin
      if (wr.we === 1'b1) begin
         mem[wr.addr] <= wr.data;
      end
   end
endmodule // isx_file_model

// ### sim/tb_top.sv
/*
 * tb_top: directed bench for the instruction subset executor.
 * assumes inputs change at the falling edge and results show one edge later.
 */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // stimulus and observed signals
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic valid = 1'b0;
   isx_pkg::isx_instr_t instr = '0;
   logic [6:0] latch = 7'h00;
   logic [7:0] rdata;
   isx_pkg::isx_fwr_t fwr;
   logic [7:0] acc;
   logic carry, zero, pc_load, nop, skip;
   logic [14:0] tgt;
   int bad_count = 0;
   int checks_done = 0;

   // 100 MHz clock
   always #5 ref_clk = ~ref_clk;

   isx_exec uut (.REF_CLK(ref_clk), .RESETN(resetn), .INSTR_VALID(valid), .INSTR(instr),
      .FILE_RDATA(rdata), .PC_HIGH_LATCH(latch), .FILE_WR(fwr), .ACC(acc), .CARRY(carry),
      .ZERO(zero), .PC_LOAD(pc_load), .PC_TARGET(tgt), .NOP_CYCLE(nop), .SKIP_TAKEN(skip));

   isx_file_model fm (.clk(ref_clk), .addr(instr.faddr), .rdata(rdata), .wr(fwr));

   // compare and count
   task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // offer one word at a falling edge, return at the next one (result settled)
   // valid stays high so back-to-back words never toggle it twice in a step
   task automatic run(isx_pkg::isx_op_t op, logic [6:0] fa, logic d, logic [10:0] k,
         logic [7:0] fv);
      fm.mem[fa] = fv;
      instr.op = op;
      instr.faddr = fa;
      instr.dest = d;
      instr.lit = k;
      valid = 1'b1;
      @(negedge ref_clk);
   endtask

   task automatic idle();
      valid = 1'b0;
      @(negedge ref_clk);
   endtask

   task automatic t_or();
      run(isx_pkg::ISX_OP_OR_LIT, 7'h00, 1'b1, 11'h700, 8'h00);
      chk("or lit acc", acc, 16'h0000);
      chk("or lit z", zero, 16'h0001);
      chk("or lit we", fwr.we, 16'h0000);
      run(isx_pkg::ISX_OP_OR_LIT, 7'h00, 1'b1, 11'h00f, 8'h00);
      chk("or lit acc2", acc, 16'h000f);
      chk("or lit z2", zero, 16'h0000);
      run(isx_pkg::ISX_OP_OR_FILE, 7'h7f, 1'b0, 11'h000, 8'h30);
      chk("or file acc", acc, 16'h003f);
      run(isx_pkg::ISX_OP_OR_FILE, 7'h7f, 1'b1, 11'h000, 8'h40);
      chk("or file wr", fwr, 16'hff7f);
      chk("or file acc kept", acc, 16'h003f);
      idle();
      $display("test or done");
   endtask

   task automatic t_inc();
      run(isx_pkg::ISX_OP_INC, 7'h05, 1'b0, 11'h000, 8'hff);
      chk("inc acc", acc, 16'h0000);
      chk("inc z", zero, 16'h0001);
      chk("inc nop", nop, 16'h0000);
      chk("inc we", fwr.we, 16'h0000);
      run(isx_pkg::ISX_OP_INC, 7'h00, 1'b1, 11'h000, 8'h41);
      chk("inc wr", fwr, 16'h8042);
      chk("inc z2", zero, 16'h0000);
      idle();
      $display("test inc done");
   endtask

   task automatic t_skip();
      run(isx_pkg::ISX_OP_INC_SKIP, 7'h11, 1'b1, 11'h000, 8'hff);
      chk("incsz wr", fwr, 16'h9100);
      chk("incsz nop", {nop, skip}, 16'h0003);
      chk("incsz z kept", zero, 16'h0000);
      run(isx_pkg::ISX_OP_OR_LIT, 7'h00, 1'b0, 11'h0ff, 8'h00);
      chk("refused acc", acc, 16'h0000);
      chk("after nop", {nop, skip}, 16'h0000);
      run(isx_pkg::ISX_OP_DEC_SKIP, 7'h12, 1'b0, 11'h000, 8'h01);
      chk("decsz acc", acc, 16'h0000);
      chk("decsz nop", {nop, skip}, 16'h0003);
      run(isx_pkg::ISX_OP_DEC_SKIP, 7'h12, 1'b0, 11'h000, 8'h03);
      chk("decsz refused", acc, 16'h0000);
      run(isx_pkg::ISX_OP_DEC_SKIP, 7'h12, 1'b0, 11'h000, 8'h03);
      chk("decsz acc2", acc, 16'h0002);
      chk("decsz no skip", {nop, skip}, 16'h0000);
      run(isx_pkg::ISX_OP_INC_SKIP, 7'h13, 1'b0, 11'h000, 8'h7f);
      chk("incsz acc", acc, 16'h0080);
      chk("incsz no skip", {nop, skip, zero}, 16'h0000);
      idle();
      $display("test skip done");
   endtask

   task automatic t_shift();
      run(isx_pkg::ISX_OP_SHL, 7'h20, 1'b0, 11'h000, 8'h81);
      chk("shl acc", acc, 16'h0002);
      chk("shl cz", {carry, zero}, 16'h0002);
      run(isx_pkg::ISX_OP_SHL, 7'h21, 1'b1, 11'h000, 8'h80);
      chk("shl wr", fwr, 16'ha100);
      chk("shl wr data", fwr.data, 16'h0000);
      chk("shl cz2", {carry, zero}, 16'h0003);
      run(isx_pkg::ISX_OP_SHR, 7'h22, 1'b0, 11'h000, 8'h01);
      chk("shr acc", acc, 16'h0000);
      chk("shr cz", {carry, zero}, 16'h0003);
      run(isx_pkg::ISX_OP_SHR, 7'h00, 1'b1, 11'h000, 8'h80);
      chk("shr wr", fwr, 16'h8040);
      chk("shr cz2", {carry, zero}, 16'h0000);
      idle();
      $display("test shift done");
   endtask

   task automatic t_branch();
      latch = 7'h50;
      run(isx_pkg::ISX_OP_BRANCH, 7'h00, 1'b1, 11'h123, 8'h00);
      chk("br target", tgt, 16'h5123);
      chk("br pulses", {pc_load, nop, fwr.we}, 16'h0006);
      chk("br flags", {carry, zero}, 16'h0000);
      run(isx_pkg::ISX_OP_OR_LIT, 7'h00, 1'b0, 11'h0ff, 8'h00);
      chk("br refused", {pc_load, nop, acc}, 16'h0000);
      chk("br hold", tgt, 16'h5123);
      idle();
      $display("test branch done");
   endtask

   // bounded run: a hang counts as a mismatch
   initial begin
      repeat (2000) @(posedge ref_clk);
      bad_count++;
      tally_and_finish();
   end

   initial begin
      repeat (3) @(negedge ref_clk);
      chk("rst state", {pc_load, nop, skip, carry, zero, acc}, 16'h0000);
      chk("rst target", tgt, 16'h0000);
      resetn = 1'b1;
      @(negedge ref_clk);
      $display("test reset done");
      t_or();
      t_inc();
      t_skip();
      t_shift();
      t_branch();
      tally_and_finish();
   end
endmodule // tb_top
